// [bench/ptc_far_model.sv]
// Far-side model: user datapath packet activity and capture of generated pause frames
`timescale 1ns/1ps
`default_nettype none
module ptc_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Frame stream and halt indication from the controller
  input wire ptc_pkg::ptc_byte_t pause_tx,
  input wire logic halted,
  // Packet activity
  input wire logic busy_req,
  output logic pkt_busy
);
  import ptc_pkg::*;
  logic [7:0] fb [0:63];
  int len_ff;
  int nfr_ff;
  int cyc_ff;
  int sop_cyc;
  // ****************************************************************
  // Frame capture
  // ****************************************************************
  // Cycle stamp lets the bench measure beat spacing between frame starts
  always_ff @(posedge clk) begin
    cyc_ff <= cyc_ff + 1;
    if (pause_tx.valid) begin
      fb[pause_tx.sop ? 0 : len_ff] <= pause_tx.data;
      len_ff <= pause_tx.sop ? 1 : len_ff + 1;
      if (pause_tx.sop) sop_cyc <= cyc_ff;
      if (pause_tx.eop) nfr_ff <= nfr_ff + 1;
    end
  end
  // ****************************************************************
  // Packet activity
  // ****************************************************************
  // A packet in flight finishes; a new one never starts while halted
  always_ff @(posedge clk) begin
    if (srst) begin
      pkt_busy <= 1'b0;
    end else if (!pkt_busy) begin
      pkt_busy <= busy_req && !halted;
    end else begin
      pkt_busy <= busy_req;
    end
  end
endmodule : ptc_far_model
`default_nettype wire

// [bench/tb.sv]
// Testbench: register bus, pause triggers, frame content, halt and loopback
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  import ptc_pkg::*;
  logic CLK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0] AWADDR, ARADDR, PRIO_XOFF;
  logic [31:0] WDATA, RDATA, PH_IN, PH_OUT;
  logic [1:0] BRESP, RRESP;
  logic PORT_XOFF, HALT_REQ, PKT_BUSY, HALTED, RXD, RXRST, RX_STAT, BUSY_REQ;
  logic [15:0] RXT;
  logic [63:0] CT_IN, DT_IN, CT_OUT, DT_OUT;
  ptc_byte_t PAUSE_TX;
  int err_total, checked;
  logic [31:0] rd;
  logic [1:0] rs;
  int t1;
  // Clock: 25 ns period
  always #12.5 CLK = ~CLK;
  ptc_top DUT (.CLK(CLK), .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .PORT_XOFF_REQUEST(PORT_XOFF),
    .PRIORITY_XOFF_REQUEST(PRIO_XOFF), .HALT_REQUEST(HALT_REQ), .PKT_BUSY(PKT_BUSY), .HALTED(HALTED),
    .RX_PORT_FRAME_DONE(RXD), .RX_PORT_FRAME_TIME(RXT), .RX_PAUSE_SYNC_RESET(RXRST),
    .RX_PORT_PAUSE_STATUS(RX_STAT), .PAUSE_TX(PAUSE_TX), .RX_LOOP_CLOCK_PHASE_IN(PH_IN),
    .RX_LOOP_CONTROL_IN(CT_IN), .RX_LOOP_DATA_IN(DT_IN), .LOOP_CLOCK_PHASE_OUT(PH_OUT),
    .LOOP_CONTROL_OUT(CT_OUT), .LOOP_DATA_OUT(DT_OUT));
  ptc_far_model u_far (.clk(CLK), .srst(SRST), .pause_tx(PAUSE_TX), .halted(HALTED),
    .busy_req(BUSY_REQ), .pkt_busy(PKT_BUSY));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic tmo;
    err_total++;
    $display("Error at %0t: wait timed out, got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  endtask : tmo
  // Readies are registered, so the value at the falling edge is the one the next rising edge sees
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic sa, sw, b;
    b = 1'b0;
    @(posedge CLK);
    AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    for (n = 0; n < 100 && !b; n++) begin
      @(negedge CLK);
      sa = AWVALID & AWREADY; sw = WVALID & WREADY; b = BVALID; r = BRESP;
      @(posedge CLK);
      if (sa) AWVALID <= 1'b0;
      if (sw) WVALID <= 1'b0;
      if (b) BREADY <= 1'b0;
    end
    if (!b) tmo();
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic sa, b;
    b = 1'b0;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    for (n = 0; n < 100 && !b; n++) begin
      @(negedge CLK);
      sa = ARVALID & ARREADY; b = RVALID; d = RDATA; r = RRESP;
      @(posedge CLK);
      if (sa) ARVALID <= 1'b0;
      if (b) RREADY <= 1'b0;
    end
    if (!b) tmo();
  endtask : axr
  task automatic wait_frame;
    int n, n0;
    n0 = u_far.nfr_ff;
    for (n = 0; n < 400 && u_far.nfr_ff == n0; n++) @(negedge CLK);
    if (u_far.nfr_ff == n0) tmo();
  endtask : wait_frame
  task automatic no_frame;
    int n0;
    n0 = u_far.nfr_ff;
    repeat (300) @(negedge CLK);
    `CHK(u_far.nfr_ff, n0)
  endtask : no_frame
  // Checks the fixed header, one two-byte field and the check sequence, sent low byte first
  task automatic chk_frame(input logic [15:0] op, input int off, input logic [15:0] val);
    logic [31:0] c;
    int i, k;
    c = 32'hffffffff;
    for (i = 0; i < 60; i++) begin
      c = c ^ {24'h0, u_far.fb[i]};
      for (k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ PTC_CRC_POLY) : (c >> 1);
    end
    `CHK(u_far.len_ff, 64)
    for (i = 0; i < 12; i++) `CHK(u_far.fb[i], (i < 6) ? PTC_DA[47-8*i -: 8] : 8'h00)
    `CHK({u_far.fb[12], u_far.fb[13]}, PTC_TYPE)
    `CHK({u_far.fb[14], u_far.fb[15]}, op)
    `CHK({u_far.fb[off], u_far.fb[off+1]}, val)
    `CHK({u_far.fb[63], u_far.fb[62], u_far.fb[61], u_far.fb[60]}, ~c)
  endtask : chk_frame
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    axr(PTC_REG_CTRL, rd, rs);
    `CHK(rd, 32'h0)
    axr(8'h30, rd, rs);
    `CHK(rs, PTC_RESP_SLVERR)
    axw(8'h30, 32'hffffffff, rs);
    `CHK(rs, PTC_RESP_SLVERR)
    axw(PTC_REG_PORT, 32'h00001234, rs);
    `CHK(rs, PTC_RESP_OKAY)
    axr(PTC_REG_PORT, rd, rs);
    `CHK(rd, 32'h00001234)
    $display("test regs done");
  endtask : t_regs
  task automatic t_force;
    axw(PTC_REG_CTRL, 32'h5, rs);
    wait_frame();
    chk_frame(PTC_OP_PORT, 16, 16'h1234);
    $display("test force done");
  endtask : t_force
  task automatic t_port_xoff;
    @(posedge CLK) PORT_XOFF <= 1'b1;
    wait_frame();
    chk_frame(PTC_OP_PORT, 16, 16'h1234);
    @(posedge CLK) PORT_XOFF <= 1'b0;
    wait_frame();
    chk_frame(PTC_OP_PORT, 16, 16'h0000);
    axw(PTC_REG_CTRL, 32'h0, rs);
    @(posedge CLK) PORT_XOFF <= 1'b1;
    no_frame();
    $display("test port xoff done");
  endtask : t_port_xoff
  task automatic t_pfc;
    axw(PTC_REG_PFC_EN, 32'h08, rs);
    axw(PTC_REG_PFC_T0 + 8'h04, 32'habcd5555, rs);
    @(posedge CLK) PRIO_XOFF <= 8'h08;
    wait_frame();
    chk_frame(PTC_OP_PFC, 24, 16'habcd);
    `CHK({u_far.fb[16], u_far.fb[17]}, 16'h0008)
    `CHK({u_far.fb[22], u_far.fb[23]}, 16'h0000)
    @(posedge CLK) PRIO_XOFF <= 8'h28;
    no_frame();
    axw(PTC_REG_CTRL, 32'h21, rs);
    wait_frame();
    chk_frame(PTC_OP_PFC, 24, 16'habcd);
    $display("test priority done");
  endtask : t_pfc
  task automatic t_beat;
    axw(PTC_REG_BEAT, 32'd20, rs);
    axw(PTC_REG_CTRL, 32'h6, rs);
    wait_frame();
    t1 = u_far.sop_cyc;
    wait_frame();
    `CHK(u_far.sop_cyc - t1, 21 * PTC_QUANTUM_CYC)
    axw(PTC_REG_CTRL, 32'h4, rs);
    repeat (200) @(posedge CLK);
    no_frame();
    $display("test beat done");
  endtask : t_beat
  task automatic t_halt;
    int n;
    @(posedge CLK) BUSY_REQ <= 1'b1;
    repeat (3) @(posedge CLK);
    HALT_REQ <= 1'b1;
    repeat (6) @(negedge CLK);
    `CHK(HALTED, 1'b0)
    @(posedge CLK) BUSY_REQ <= 1'b0;
    for (n = 0; n < 20 && HALTED !== 1'b1; n++) @(negedge CLK);
    `CHK(HALTED, 1'b1)
    @(posedge CLK) HALT_REQ <= 1'b0;
    for (n = 0; n < 20 && HALTED !== 1'b0; n++) @(negedge CLK);
    `CHK(HALTED, 1'b0)
    $display("test halt done");
  endtask : t_halt
  task automatic t_loop_rx;
    @(posedge CLK) PH_IN <= 32'h1234abcd; CT_IN <= 64'hff00; DT_IN <= 64'h0123456789abcdef;
    RXT <= 16'h0005; RXD <= 1'b1;
    @(posedge CLK) RXD <= 1'b0;
    repeat (3) @(negedge CLK);
    `CHK({PH_OUT, CT_OUT, DT_OUT}, 160'h0)
    `CHK(RX_STAT, 1'b1)
    @(posedge CLK) RXRST <= 1'b1;
    @(posedge CLK) RXRST <= 1'b0;
    axw(PTC_REG_CTRL, 32'h8, rs);
    repeat (3) @(negedge CLK);
    `CHK(RX_STAT, 1'b0)
    `CHK({PH_OUT, CT_OUT, DT_OUT}, {PH_IN, CT_IN, DT_IN})
    @(posedge CLK) RXD <= 1'b1;
    @(posedge CLK) RXD <= 1'b0;
    @(negedge CLK) `CHK(RX_STAT, 1'b1)
    axw(PTC_REG_CTRL, 32'h18, rs);
    @(negedge CLK) `CHK(RX_STAT, 1'b0)
    $display("test loop and rx done");
  endtask : t_loop_rx
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    CLK = 1'b0; SRST = 1'b1; AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0;
    RREADY = 1'b0; AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0; PORT_XOFF = 1'b0; PRIO_XOFF = 8'h00;
    HALT_REQ = 1'b0; BUSY_REQ = 1'b0; RXD = 1'b0; RXT = 16'h0; RXRST = 1'b0; PH_IN = 32'h0;
    CT_IN = 64'h0; DT_IN = 64'h0; err_total = 0; checked = 0;
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    t_regs();
    t_force();
    t_port_xoff();
    t_pfc();
    t_beat();
    t_halt();
    t_loop_rx();
    final_report();
  end
endmodule : tb
`default_nettype wire

// [hw/ptc_pkg.sv]
// Package: constants and carrier types of the pause frame transmit controller
package ptc_pkg;
  // ****************************************************************
  // AXI4-Lite register map
  // ****************************************************************
  localparam logic [7:0] PTC_REG_CTRL = 8'h00;    // Control and build-free options
  localparam logic [7:0] PTC_REG_PORT = 8'h04;    // Port pause time
  localparam logic [7:0] PTC_REG_BEAT = 8'h08;    // Beat interval
  localparam logic [7:0] PTC_REG_PFC_EN = 8'h0c;  // Priority pause enables
  localparam logic [7:0] PTC_REG_PFC_T0 = 8'h10;  // Priority times, one word per pair
  localparam logic [7:0] PTC_REG_STATUS = 8'h20;  // Status
  localparam logic [7:0] PTC_REG_SENT = 8'h24;    // Frames sent counter
  localparam int PTC_PFC_WORDS = 4;
  // Control bit positions
  localparam int PTC_CTL_SEND = 0;     // Write 1: force one frame (self clearing)
  localparam int PTC_CTL_BEAT_EN = 1;
  localparam int PTC_CTL_PORT_EN = 2;
  localparam int PTC_CTL_LOOP_EN = 3;
  localparam int PTC_CTL_RXRST = 4;    // Write 1: reset receive pause status (self clearing)
  localparam int PTC_CTL_PFC_SEL = 5;  // Forced frame is priority kind when set
  localparam logic [1:0] PTC_RESP_OKAY = 2'b00;
  localparam logic [1:0] PTC_RESP_SLVERR = 2'b10;
  // ****************************************************************
  // Frame and timing constants
  // ****************************************************************
  localparam logic [47:0] PTC_DA = 48'h0180c2000001;  // Reserved control multicast
  localparam logic [15:0] PTC_TYPE = 16'h8808;        // MAC control ethertype
  localparam logic [15:0] PTC_OP_PORT = 16'h0001;
  localparam logic [15:0] PTC_OP_PFC = 16'h0101;
  localparam int PTC_FRAME_BYTES = 60;                // Before the frame check sequence
  localparam int PTC_FCS_BYTES = 4;
  localparam int PTC_QUANTUM_UI = 512;
  localparam int PTC_UI_PER_CYCLE = 64;               // 64-bit datapath, one word per cycle
  localparam int PTC_QUANTUM_CYC = PTC_QUANTUM_UI / PTC_UI_PER_CYCLE;
  localparam logic [31:0] PTC_CRC_POLY = 32'hedb88320;
  typedef enum logic [1:0] {
    PTC_ST_IDLE = 2'b00,
    PTC_ST_SEND = 2'b01,
    PTC_ST_FCS = 2'b10
  } ptc_state_t;
  // Transmit byte stream carrier
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
  } ptc_byte_t;
endpackage : ptc_pkg

// [hw/ptc_top.sv]
// Pause frame transmit controller: triggers, frame generator, halt logic, register slave
// ****************************************************************
// Behaviour
// - Send strobe pulse forces one pause frame when new-pause option is built in
// - Beat enable high sends pause frames repeatedly, spaced by the beat interval; the code spaces them by the interval plus one quantum
// - Beat interval is 16 bits, counted in units of 512 UI
// - Beat works only with both new-pause and timer options built in
// - Port frames only while port enable high; port time gives their quanta
// - Each priority enable bit permits priority frames for that class
// - Priority time word splits into eight 16-bit fields, lowest for priority 0
// - Any level change of port XOFF request sends one port pause frame
// - Port XOFF frame carries zero when request low, port time when high
// - Port XOFF honoured only with new-pause option and port enable
// - A change on any priority XOFF bit sends a priority pause frame
// - Priority x timer is zero when bit low, its field when high
// - Priority bit x honoured only with new-pause option and enable bit x
// - While halt request is high, packet transmission stops
// - Halted indication high while transmission is suspended by the halt request
// - Receive loopback words pass to outputs only while local loopback enabled
// - Pause receive reset clears the receive pause status
// - Port pause status rises after a received port frame with non-zero time
// ****************************************************************
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ptc_top #(
  parameter bit NEW_PAUSE = 1'b1,
  parameter bit PAUSE_TIMER = 1'b1,
  parameter int LOOP_W = 64
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Data-plane pause requests
  input wire logic PORT_XOFF_REQUEST,
  input wire logic [7:0] PRIORITY_XOFF_REQUEST,
  input wire logic HALT_REQUEST,
  input wire logic PKT_BUSY,
  output logic HALTED,
  // Received pause frame reports
  input wire logic RX_PORT_FRAME_DONE,
  input wire logic [15:0] RX_PORT_FRAME_TIME,
  input wire logic RX_PAUSE_SYNC_RESET,
  output logic RX_PORT_PAUSE_STATUS,
  // Generated frame byte stream
  output ptc_pkg::ptc_byte_t PAUSE_TX,
  // Local loopback
  input wire logic [31:0] RX_LOOP_CLOCK_PHASE_IN,
  input wire logic [LOOP_W-1:0] RX_LOOP_CONTROL_IN,
  input wire logic [LOOP_W-1:0] RX_LOOP_DATA_IN,
  output logic [31:0] LOOP_CLOCK_PHASE_OUT,
  output logic [LOOP_W-1:0] LOOP_CONTROL_OUT,
  output logic [LOOP_W-1:0] LOOP_DATA_OUT
);
  import ptc_pkg::*;

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [15:0] port_time_ff, beat_time_ff;
  logic [7:0] pfc_en_ff;
  logic [127:0] pfc_time_ff;
  logic [15:0] sent_ff;
  logic pend_port_ff, pend_pfc_ff;
  logic send_pulse, rx_sw_reset;
  logic aw_ok, w_ok;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  assign aw_ok = AWVALID && AWREADY;
  assign w_ok = WVALID && WREADY;

  // Capture address and data in either order; answer once both arrived
  always_ff @(posedge CLK) begin
    if (SRST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= PTC_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
    end else begin
      if (aw_ok) begin
        AWREADY <= 1'b0;
        awaddr_ff <= AWADDR;
      end
      if (w_ok) begin
        WREADY <= 1'b0;
        wdata_ff <= WDATA;
      end
      if (!AWREADY && !WREADY && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= (awaddr_ff <= PTC_REG_PFC_T0 + 8'h0c) ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // Register writes; pulse bits self clear so a write of one is a single strobe
  logic do_write;
  assign do_write = !AWREADY && !WREADY && !BVALID;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl_ff <= 32'h0;
      port_time_ff <= 16'h0;
      beat_time_ff <= 16'h0;
      pfc_en_ff <= 8'h0;
      pfc_time_ff <= 128'h0;
    end else begin
      ctrl_ff[PTC_CTL_SEND] <= 1'b0;
      ctrl_ff[PTC_CTL_RXRST] <= 1'b0;
      if (do_write) begin
        unique case (awaddr_ff)
          PTC_REG_CTRL: ctrl_ff <= {26'h0, wdata_ff[5:0]};
          PTC_REG_PORT: port_time_ff <= wdata_ff[15:0];
          PTC_REG_BEAT: beat_time_ff <= wdata_ff[15:0];
          PTC_REG_PFC_EN: pfc_en_ff <= wdata_ff[7:0];
          PTC_REG_PFC_T0: pfc_time_ff[31:0] <= wdata_ff;
          PTC_REG_PFC_T0 + 8'h04: pfc_time_ff[63:32] <= wdata_ff;
          PTC_REG_PFC_T0 + 8'h08: pfc_time_ff[95:64] <= wdata_ff;
          PTC_REG_PFC_T0 + 8'h0c: pfc_time_ff[127:96] <= wdata_ff;
          default: ;
        endcase
      end
    end
  end
  assign send_pulse = ctrl_ff[PTC_CTL_SEND];
  assign rx_sw_reset = ctrl_ff[PTC_CTL_RXRST];

  // Read channel: one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= PTC_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= PTC_RESP_OKAY;
      unique case (ARADDR)
        PTC_REG_CTRL: RDATA <= ctrl_ff;
        PTC_REG_PORT: RDATA <= {16'h0, port_time_ff};
        PTC_REG_BEAT: RDATA <= {16'h0, beat_time_ff};
        PTC_REG_PFC_EN: RDATA <= {24'h0, pfc_en_ff};
        PTC_REG_PFC_T0: RDATA <= pfc_time_ff[31:0];
        PTC_REG_PFC_T0 + 8'h04: RDATA <= pfc_time_ff[63:32];
        PTC_REG_PFC_T0 + 8'h08: RDATA <= pfc_time_ff[95:64];
        PTC_REG_PFC_T0 + 8'h0c: RDATA <= pfc_time_ff[127:96];
        PTC_REG_STATUS: RDATA <= {28'h0, pend_port_ff, pend_pfc_ff, HALTED, RX_PORT_PAUSE_STATUS};
        PTC_REG_SENT: RDATA <= {16'h0, sent_ff};
        default: begin
          RDATA <= 32'h0;
          RRESP <= PTC_RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ****************************************************************
  // Triggers and queue
  // ****************************************************************
  logic port_xoff_ff;
  logic [7:0] pfc_xoff_ff;
  logic port_edge, port_from_xoff_ff;
  logic port_en, beat_on, beat_fire;
  logic [7:0] pfc_ok;
  logic [15:0] beat_cnt_ff;
  logic [2:0] quanta_div_ff;
  logic take_port, take_pfc;
  assign port_en = NEW_PAUSE && ctrl_ff[PTC_CTL_PORT_EN];
  assign pfc_ok = NEW_PAUSE ? pfc_en_ff : 8'h0;
  assign beat_on = NEW_PAUSE && PAUSE_TIMER && ctrl_ff[PTC_CTL_BEAT_EN];
  assign port_edge = port_en && (PORT_XOFF_REQUEST != port_xoff_ff);

  // Beat timer: one quantum of 512 UI is eight cycles of the 64-bit datapath
  always_ff @(posedge CLK) begin
    if (SRST || !beat_on) begin
      quanta_div_ff <= 3'h0;
      beat_cnt_ff <= 16'h0;
    end else begin
      quanta_div_ff <= quanta_div_ff + 3'h1;
      if (quanta_div_ff == 3'(PTC_QUANTUM_CYC - 1)) begin
        beat_cnt_ff <= beat_fire ? 16'h0 : beat_cnt_ff + 16'h1;
      end
    end
  end
  assign beat_fire = beat_on && (quanta_div_ff == 3'(PTC_QUANTUM_CYC - 1)) && (beat_cnt_ff >= beat_time_ff);

  // Request edges; an arriving trigger beats the dequeue in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_xoff_ff <= 1'b0;
      pfc_xoff_ff <= 8'h0;
      pend_port_ff <= 1'b0;
      pend_pfc_ff <= 1'b0;
      port_from_xoff_ff <= 1'b0;
    end else begin
      port_xoff_ff <= PORT_XOFF_REQUEST;
      pfc_xoff_ff <= PRIORITY_XOFF_REQUEST;
      if (port_edge
          || (NEW_PAUSE && (send_pulse && !ctrl_ff[PTC_CTL_PFC_SEL] || beat_fire) && port_en)) begin
        pend_port_ff <= 1'b1;
        // A queued request-level frame keeps its zero-when-low meaning even if a force joins it
        port_from_xoff_ff <= port_edge || (pend_port_ff && !take_port && port_from_xoff_ff);
      end else if (take_port) begin
        pend_port_ff <= 1'b0;
      end
      if ((|(pfc_ok & (PRIORITY_XOFF_REQUEST ^ pfc_xoff_ff)))
          || (NEW_PAUSE && send_pulse && ctrl_ff[PTC_CTL_PFC_SEL] && |pfc_ok)) begin
        pend_pfc_ff <= 1'b1;
      end else if (take_pfc) begin
        pend_pfc_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Frame generator
  // ****************************************************************
  ptc_state_t state_ff;
  logic [5:0] idx_ff;
  logic [1:0] fcs_idx_ff;
  logic kind_pfc_ff, frame_xoff_ff;
  logic [31:0] crc_ff;
  logic [7:0] cur_byte;
  logic [15:0] port_q;
  logic [127:0] pfc_q;
  logic between_pkts;
  assign between_pkts = !PKT_BUSY;
  assign take_port = (state_ff == PTC_ST_IDLE) && between_pkts && pend_port_ff;
  assign take_pfc = (state_ff == PTC_ST_IDLE) && between_pkts && !pend_port_ff && pend_pfc_ff;
  // Forced and beat frames carry the port time unless they join a queued request frame; request frames follow the level
  assign port_q = (frame_xoff_ff && !port_xoff_ff) ? 16'h0 : port_time_ff;
  always_comb begin
    pfc_q = 128'h0;
    for (int x = 0; x < 8; x++) begin
      pfc_q[x*16 +: 16] = pfc_xoff_ff[x] ? pfc_time_ff[x*16 +: 16] : 16'h0;
    end
  end

  // Byte of the frame body at the current index
  always_comb begin
    cur_byte = 8'h00;
    if (idx_ff < 6'd6) cur_byte = PTC_DA[8*(5-idx_ff) +: 8];
    else if (idx_ff < 6'd12) cur_byte = 8'h00;                // Source filled by datapath
    else if (idx_ff == 6'd12) cur_byte = PTC_TYPE[15:8];
    else if (idx_ff == 6'd13) cur_byte = PTC_TYPE[7:0];
    else if (idx_ff == 6'd14) cur_byte = kind_pfc_ff ? PTC_OP_PFC[15:8] : PTC_OP_PORT[15:8];
    else if (idx_ff == 6'd15) cur_byte = kind_pfc_ff ? PTC_OP_PFC[7:0] : PTC_OP_PORT[7:0];
    else if (!kind_pfc_ff && idx_ff == 6'd16) cur_byte = port_q[15:8];
    else if (!kind_pfc_ff && idx_ff == 6'd17) cur_byte = port_q[7:0];
    else if (kind_pfc_ff && idx_ff == 6'd17) cur_byte = pfc_ok;
    else if (kind_pfc_ff && idx_ff >= 6'd18 && idx_ff < 6'd34)
      cur_byte = pfc_q[8*((idx_ff - 6'd18) ^ 6'd1) +: 8];
  end

  // Frame sequencer, CRC and byte output
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff <= PTC_ST_IDLE;
      idx_ff <= 6'h0;
      fcs_idx_ff <= 2'h0;
      kind_pfc_ff <= 1'b0;
      frame_xoff_ff <= 1'b0;
      crc_ff <= 32'hffffffff;
      PAUSE_TX <= '0;
      sent_ff <= 16'h0;
    end else begin
      PAUSE_TX <= '0;
      unique case (state_ff)
        PTC_ST_IDLE: begin
          idx_ff <= 6'h0;
          crc_ff <= 32'hffffffff;
          if (take_port || take_pfc) begin
            kind_pfc_ff <= take_pfc;
            frame_xoff_ff <= port_from_xoff_ff;
            state_ff <= PTC_ST_SEND;
          end
        end
        PTC_ST_SEND: begin
          PAUSE_TX <= '{valid: 1'b1, sop: idx_ff == 6'h0, eop: 1'b0, data: cur_byte};
          crc_ff <= crc_step(crc_ff, cur_byte);
          idx_ff <= idx_ff + 6'h1;
          if (idx_ff == 6'(PTC_FRAME_BYTES - 1)) begin
            state_ff <= PTC_ST_FCS;
            fcs_idx_ff <= 2'h0;
          end
        end
        PTC_ST_FCS: begin
          PAUSE_TX <= '{valid: 1'b1, sop: 1'b0, eop: fcs_idx_ff == 2'(PTC_FCS_BYTES - 1),
                        data: ~crc_ff[8*fcs_idx_ff +: 8]};
          fcs_idx_ff <= fcs_idx_ff + 2'h1;
          if (fcs_idx_ff == 2'(PTC_FCS_BYTES - 1)) begin
            state_ff <= PTC_ST_IDLE;
            sent_ff <= sent_ff + 16'h1;
          end
        end
        default: state_ff <= PTC_ST_IDLE;
      endcase
    end
  end

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ PTC_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_step

  // ****************************************************************
  // Halt, receive status and loopback
  // ****************************************************************
  // Halt takes effect only between packets so no packet is cut short
  always_ff @(posedge CLK) begin
    if (SRST) HALTED <= 1'b0;
    else if (!HALT_REQUEST) HALTED <= 1'b0;
    else if (!PKT_BUSY) HALTED <= 1'b1;
  end

  // Receive pause status: reset by the pin or by software
  always_ff @(posedge CLK) begin
    if (SRST || RX_PAUSE_SYNC_RESET || rx_sw_reset) RX_PORT_PAUSE_STATUS <= 1'b0;
    else if (RX_PORT_FRAME_DONE) RX_PORT_PAUSE_STATUS <= (RX_PORT_FRAME_TIME != 16'h0);
  end

  // Loopback words are zero while loopback is off
  always_ff @(posedge CLK) begin
    if (SRST || !ctrl_ff[PTC_CTL_LOOP_EN]) begin
      LOOP_CLOCK_PHASE_OUT <= 32'h0;
      LOOP_CONTROL_OUT <= '0;
      LOOP_DATA_OUT <= '0;
    end else begin
      LOOP_CLOCK_PHASE_OUT <= RX_LOOP_CLOCK_PHASE_IN;
      LOOP_CONTROL_OUT <= RX_LOOP_CONTROL_IN;
      LOOP_DATA_OUT <= RX_LOOP_DATA_IN;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_frame_start;
    PAUSE_TX.valid && PAUSE_TX.sop;
  endsequence
  a_halt_follow: assert property (@(posedge CLK) disable iff (SRST) !HALT_REQUEST |=> !HALTED)
    else $error("halted stays high after request dropped");
  a_halt_idle: assert property (@(posedge CLK) disable iff (SRST) HALT_REQUEST && !PKT_BUSY |=> HALTED)
    else $error("halt not shown between packets");
  a_port_edge: assert property (@(posedge CLK) disable iff (SRST)
      port_en && $changed(PORT_XOFF_REQUEST) |=> pend_port_ff)
    else $error("port request change not queued");
  a_port_gate: assert property (@(posedge CLK) disable iff (SRST)
      !port_en && !pend_port_ff |=> !pend_port_ff)
    else $error("port frame queued while port pause disabled");
  a_frame_len: assert property (@(posedge CLK) disable iff (SRST)
      s_frame_start |-> ##63 (PAUSE_TX.valid && PAUSE_TX.eop))
    else $error("pause frame length wrong");
  a_rx_status: assert property (@(posedge CLK) disable iff (SRST)
      RX_PAUSE_SYNC_RESET |=> !RX_PORT_PAUSE_STATUS)
    else $error("receive status not reset");
  a_rx_set: assert property (@(posedge CLK) disable iff (SRST)
      RX_PORT_FRAME_DONE && RX_PORT_FRAME_TIME != 16'h0 && !RX_PAUSE_SYNC_RESET && !rx_sw_reset
      |=> RX_PORT_PAUSE_STATUS)
    else $error("receive status not set");
  a_no_cut: assert property (@(posedge CLK) disable iff (SRST)
      PKT_BUSY && state_ff == PTC_ST_IDLE |=> state_ff == PTC_ST_IDLE)
    else $error("frame started inside a packet");
  a_beat_queue: assert property (@(posedge CLK) disable iff (SRST)
      beat_fire && port_en |=> pend_port_ff)
    else $error("beat did not queue a frame");
endmodule : ptc_top
`default_nettype wire
